// file: testbench/tmr_core_tb.sv
// Self-checking bench for the reload/capture timer
`timescale 1ns/10ps
module tmr_core_tb import tmr_pkg::*;;
    logic clk;
    logic rst_n;
    logic ce;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [7:0] rdata_r;
    logic cnt_req;
    logic trig_req;
    logic trig_hold_low;
    logic count_pin;
    logic trig_pin;
    logic other_tick;
    logic pin_out;
    logic pin_oe;
    logic tx_tick;
    logic rx_tick;
    logic irq;
    int n_mismatch;
    int tests_run;
    int cycles;
    int n_tog;
    int n_tx;
    int n_rx;
    logic [7:0] rst_addrs [8] = '{8'hc8, 8'hc9, 8'ha8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h00};

    tmr_core tmr_core_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata_r(rdata_r), .shared_port_pin_in(count_pin), .external_trigger_pin(trig_pin),
        .other_timer_tx_tick(other_tick), .other_timer_rx_tick(other_tick), .shared_port_pin_out_r(pin_out),
        .shared_port_pin_oe_r(pin_oe), .tx_baud_tick_r(tx_tick), .rx_baud_tick_r(rx_tick), .irq_r(irq));

    tmr_pin_model tmr_pin_model_inst (.clk(clk), .rst_n(rst_n), .cnt_req(cnt_req), .trig_req(trig_req),
        .trig_hold_low(trig_hold_low), .count_pin(count_pin), .trig_pin(trig_pin), .other_tick(other_tick));

    // ****************************************
    // Clock, timeout and reporting
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Whole sequence needs about 350 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_n(input int got, input int exp);
        tests_run = tests_run + 1;
        if (got != exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_n

    // ****************************************
    // Bus and pin tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata_r;
    endtask : rd

    task automatic pulse(input bit trig);
        @(posedge clk);
        if (trig)
            trig_req <= 1'b1;
        else
            cnt_req <= 1'b1;
        @(posedge clk);
        trig_req <= 1'b0;
        cnt_req <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : pulse

    // Counts pin toggles and tick pulses over 40 cycles
    task automatic window();
        logic last;
        repeat (8) @(posedge clk);
        #1;
        last = pin_out;
        n_tog = 0;
        n_tx = 0;
        n_rx = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            n_tog += (pin_out !== last);
            n_tx += (tx_tick === 1'b1);
            n_rx += (rx_tick === 1'b1);
            last = pin_out;
        end
    endtask : window

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        logic [7:0] d;
        int k;
        n_mismatch = 0;
        tests_run = 0;
        cycles = 0;
        rst_n = 1'b0;
        {addr, wdata, wr_en, rd_en, cnt_req, trig_req, trig_hold_low} = '0;
        ce = 1'b1;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rst_addrs[i]) begin
            rd(rst_addrs[i], d);
            chk8(d, 8'h00);
        end
        wr(8'hc9, 8'hff);
        rd(8'hc9, d);
        chk8(d, 8'h03);
        wr(8'hc9, 8'h00);
        $display("Reset and register test done");

        wr(8'hca, 8'hfe);
        wr(8'hcb, 8'hff);
        wr(8'hcc, 8'hff);
        wr(8'hcd, 8'hff);
        wr(8'ha8, 8'ha0);
        wr(8'hc8, 8'h04);
        k = 0;
        while (irq !== 1'b1 && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk8(irq, 1'b1);
        rd(8'hcc, d);
        chk8(d, 8'hfe);
        rd(8'hc8, d);
        chk8(d, 8'h84);
        wr(8'ha8, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk8(irq, 1'b0);
        $display("Auto-reload up test done");

        wr(8'hc8, 8'h00);
        wr(8'ha8, 8'ha0);
        // Known count of ffff so one pin fall wraps it
        wr(8'hcc, 8'hff);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h0f);
        pulse(1'b1);
        rd(8'hca, d);
        chk8(d, 8'hff);
        rd(8'hc8, d);
        chk8(d, 8'h4f);
        chk8(irq, 1'b1);
        pulse(1'b0);
        rd(8'hcd, d);
        chk8(d, 8'h00);
        rd(8'hc8, d);
        chk8(d, 8'hcf);
        rd(8'hcb, d);
        chk8(d, 8'hff);
        $display("Capture test done");

        wr(8'hc8, 8'h00);
        wr(8'hcc, 8'h10);
        wr(8'hcd, 8'h00);
        wr(8'hc8, 8'h0e);
        pulse(1'b1);
        rd(8'hcc, d);
        chk8(d, 8'hff);
        rd(8'hc8, d);
        chk8(d, 8'h4e);
        $display("Trigger reload test done");

        wr(8'hc8, 8'h00);
        wr(8'hc9, 8'h01);
        wr(8'hca, 8'h05);
        wr(8'hcb, 8'h00);
        wr(8'hcc, 8'h05);
        wr(8'hcd, 8'h00);
        trig_hold_low <= 1'b1;
        wr(8'hc8, 8'h06);
        pulse(1'b0);
        rd(8'hcd, d);
        chk8(d, 8'hff);
        rd(8'hc8, d);
        chk8(d, 8'hc6);
        wr(8'hc8, 8'h46);
        repeat (3) @(posedge clk);
        #1;
        chk8(irq, 1'b0);
        trig_hold_low <= 1'b0;
        pulse(1'b0);
        rd(8'hcc, d);
        chk8(d, 8'h05);
        rd(8'hc8, d);
        chk8(d, 8'h86);
        $display("Down count test done");

        wr(8'hc8, 8'h00);
        wr(8'hc9, 8'h02);
        wr(8'hca, 8'hfe);
        wr(8'hcb, 8'hff);
        // Start next to the top so rollovers come every four cycles
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h34);
        window();
        chk_n(n_tog, 10);
        chk_n(n_tx, 10);
        chk_n(n_rx, 10);
        chk8(pin_oe, 1'b1);
        rd(8'hc8, d);
        chk8(d, 8'h34);
        wr(8'hc8, 8'h04);
        window();
        chk_n(n_tog, 10);
        chk_n(n_tx, 5);
        chk_n(n_rx, 5);
        chk8(irq, 1'b0);
        // Clock enable low must freeze the clock-out pin
        ce <= 1'b0;
        window();
        chk_n(n_tog, 0);
        ce <= 1'b1;
        wr(8'hc8, 8'h00);
        wr(8'hc9, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        chk8(pin_oe, 1'b0);
        $display("Clock-out and baud test done");
        stop_test();
    end
endmodule : tmr_core_tb

// file: testbench/tmr_pin_model.sv
// Far-side model: count pin, trigger pin and the other timer's baud ticks
`timescale 1ns/10ps
module tmr_pin_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cnt_req,
    input wire logic trig_req,
    input wire logic trig_hold_low,
    output logic count_pin,
    output logic trig_pin,
    output logic other_tick
);
    logic [1:0] cnt_low_r;
    logic [1:0] trig_low_r;
    logic [2:0] div_r;

    // ****************************************
    // Pin levels
    // ****************************************
    // Both lines idle high, as pulled-up port pins do
    assign count_pin = (cnt_low_r == 2'h0);
    assign trig_pin = !trig_hold_low && (trig_low_r == 2'h0);
    assign other_tick = (div_r == 3'h7);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_low_r <= 2'h0;
            trig_low_r <= 2'h0;
            div_r <= 3'h0;
        end else begin
            // Low for three cycles so a sampled fall is never missed
            cnt_low_r <= cnt_req ? 2'h3 : cnt_low_r - {1'b0, cnt_low_r != 2'h0};
            trig_low_r <= trig_req ? 2'h3 : trig_low_r - {1'b0, trig_low_r != 2'h0};
            div_r <= div_r + 3'h1;
        end
    end
endmodule : tmr_pin_model

// file: verilog/tmr_core.sv
// Sixteen-bit reload/capture timer with clock-out and baud-tick generation
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// - 16-bit counter, timer or event counter.
// - Run, baud selects, capture select pick mode.
// - Capture without trigger: plain counter, overflow flag.
// - Trigger fall copies count into reload, flags.
// - Both flags share one readable interrupt.
// - Capture never reloads; counting continues.
// - Down count enable clears at reset.
// - Up count to ffff, flag, reload.
// - Trigger fall also reloads, sets external flag.
// - Down enabled, pin high: count up, reload.
// - Pin low: down, match reload, load ffff.
// - External flag toggles as 17th bit.
// - Clock-out needs timer source, enable, run.
// - Clock-out from reload; rollovers not interrupting.
// - Baud and clock-out share one rollover.
// - Shared pin serves as count input.
// - Interrupt gated by timer interrupt enable.
// - Baud mode increments every state time.
// - Baud rollover reloads, no overflow flag.
// - Baud selects pick this or other timer.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module tmr_core import tmr_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata_r,
    input wire logic shared_port_pin_in,
    input wire logic external_trigger_pin,
    input wire logic other_timer_tx_tick,
    input wire logic other_timer_rx_tick,
    output logic shared_port_pin_out_r,
    output logic shared_port_pin_oe_r,
    output logic tx_baud_tick_r,
    output logic rx_baud_tick_r,
    output logic irq_r
);

    // ****************************************
    // State
    // ****************************************
    tmr_ctrl_type ctrl_r, ctrl_nxt;
    tmr_mode_type mode_r, mode_nxt;
    tmr_ie_type ie_r, ie_nxt;
    logic [15:0] count_r, count_nxt;
    logic [15:0] reload_r, reload_nxt;
    logic trig_prev_r;
    logic cnt_pin_prev_r;
    logic clk_out_nxt;
    logic irq_nxt;
    logic [7:0] rdata_nxt;

    function automatic tmr_op_type decode_op(input tmr_ctrl_type c);
        if (!c.second_timer_run) begin
            decode_op = TMR_OFF;
        end else if (c.rx_baud_select | c.transmit_baud_select) begin
            decode_op = TMR_BAUD;
        end else if (c.capture_reload_select) begin
            decode_op = TMR_CAPTURE;
        end else begin
            decode_op = TMR_AUTORELOAD;
        end
    endfunction : decode_op

    // ****************************************
    // Tick selection and events
    // ****************************************
    wire state_tick;
    wire mach_tick;

    tmr_prescale u_prescale (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .state_tick(state_tick),
        .mach_tick(mach_tick)
    );

    wire tmr_op_type op_w = decode_op(ctrl_r);
    wire is_baud = (op_w == TMR_BAUD);
    wire is_cap = (op_w == TMR_CAPTURE);
    wire is_arl = (op_w == TMR_AUTORELOAD);
    // Clock-out only when the pin is not the count input
    wire clk_out_mode = mode_r.clock_out_enable & ~ctrl_r.count_source_select;
    wire fast_tick = is_baud | clk_out_mode;
    wire trig_fall = ce & trig_prev_r & ~external_trigger_pin;
    wire pin_fall = ce & cnt_pin_prev_r & ~shared_port_pin_in;
    wire timer_tick = fast_tick ? state_tick : mach_tick;
    wire src_tick = ctrl_r.count_source_select ? pin_fall : timer_tick;
    wire inc = (op_w != TMR_OFF) & src_tick;
    // Direction follows the trigger pin only in reload mode
    wire down_dir = is_arl & mode_r.down_count_enable & ~external_trigger_pin;
    wire ovf_up = inc & ~down_dir & (count_r == TMR_CNT_TOP);
    wire unf_dn = inc & down_dir & (count_r == reload_r);
    wire rollover = ovf_up | unf_dn;
    wire ext_trig = trig_fall & ctrl_r.external_enable;
    // Software register writes
    wire wr_ctrl = ce & wr_en & (addr == TMR_CTRL_ADDR);
    wire wr_mode = ce & wr_en & (addr == TMR_MODE_ADDR);
    wire wr_ie = ce & wr_en & (addr == TMR_IE_ADDR);
    wire wr_cnt_lo = ce & wr_en & (addr == TMR_CNT_LO_ADDR);
    wire wr_cnt_hi = ce & wr_en & (addr == TMR_CNT_HI_ADDR);
    wire wr_rld_lo = ce & wr_en & (addr == TMR_RLD_LO_ADDR);
    wire wr_rld_hi = ce & wr_en & (addr == TMR_RLD_HI_ADDR);
    // Hardware flag events; set beats a software clear in the same cycle
    wire set_tf = rollover & ~is_baud & ~clk_out_mode;
    wire down_count_enable_arl = is_arl & mode_r.down_count_enable;
    wire set_exf = ext_trig & ~down_count_enable_arl;
    wire tog_exf = rollover & down_count_enable_arl;
    wire ctrl_wr_val_tf = wr_ctrl ? wdata[7] : ctrl_r.overflow_flag;
    wire ctrl_wr_val_exf = wr_ctrl ? wdata[6] : ctrl_r.external_flag;
    wire reload_on_trig = is_arl & ~mode_r.down_count_enable & ext_trig;
    wire reload_on_roll = ovf_up & (is_arl | is_baud);
    wire [15:0] count_inc = down_dir ? count_r - 16'h0001 : count_r + 16'h0001;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        ctrl_nxt = wr_ctrl ? tmr_ctrl_type'(wdata) : ctrl_r;
        ctrl_nxt.overflow_flag = ctrl_wr_val_tf | set_tf;
        ctrl_nxt.external_flag = (ctrl_wr_val_exf | set_exf) ^ tog_exf;
        mode_nxt = wr_mode ? tmr_mode_type'(wdata[1:0]) : mode_r;
        ie_nxt = wr_ie ? tmr_ie_type'(wdata) : ie_r;
        // Capture mode: count wraps, never reloads
        count_nxt = count_r;
        if (unf_dn) begin
            count_nxt = TMR_CNT_TOP;
        end else if (reload_on_roll | reload_on_trig) begin
            count_nxt = reload_r;
        end else if (inc) begin
            count_nxt = count_inc;
        end
        // Software writes win; counter should be stopped first
        if (wr_cnt_lo) begin
            count_nxt[7:0] = wdata;
        end
        if (wr_cnt_hi) begin
            count_nxt[15:8] = wdata;
        end
        reload_nxt = reload_r;
        if (wr_rld_lo) begin
            reload_nxt[7:0] = wdata;
        end
        if (wr_rld_hi) begin
            reload_nxt[15:8] = wdata;
        end
        // A capture in the same cycle overrides the software write
        if (is_cap & ext_trig) begin
            reload_nxt = count_r;
        end
    end

    // Shared rollover feeds both clock-out and baud ticks
    assign clk_out_nxt = (clk_out_mode & rollover) ? ~shared_port_pin_out_r : shared_port_pin_out_r;
    // External flag is not an interrupt source with down counting
    assign irq_nxt = ie_r.all_enable & ie_r.timer_int_enable
        & (ctrl_r.overflow_flag | (ctrl_r.external_flag & ~down_count_enable_arl));

    // ****************************************
    // Read mux
    // ****************************************
    wire [7:0] rd_mux =
        (addr == TMR_CTRL_ADDR) ? ctrl_r :
        (addr == TMR_MODE_ADDR) ? {6'h00, mode_r} :
        (addr == TMR_IE_ADDR) ? ie_r :
        (addr == TMR_CNT_LO_ADDR) ? count_r[7:0] :
        (addr == TMR_CNT_HI_ADDR) ? count_r[15:8] :
        (addr == TMR_RLD_LO_ADDR) ? reload_r[7:0] :
        (addr == TMR_RLD_HI_ADDR) ? reload_r[15:8] : 8'h00;
    assign rdata_nxt = rd_en ? rd_mux : 8'h00;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= tmr_ctrl_type'(TMR_CTRL_RST);
            mode_r <= tmr_mode_type'(TMR_MODE_RST);
            ie_r <= tmr_ie_type'(TMR_IE_RST);
            count_r <= TMR_CNT_RST;
            reload_r <= TMR_RLD_RST;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
            ie_r <= ie_nxt;
            count_r <= count_nxt;
            reload_r <= reload_nxt;
        end
    end

    // Pin history starts high so reset never looks like a falling edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_prev_r <= 1'b1;
            cnt_pin_prev_r <= 1'b1;
        end else if (ce) begin
            trig_prev_r <= external_trigger_pin;
            cnt_pin_prev_r <= shared_port_pin_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shared_port_pin_out_r <= 1'b1;
            shared_port_pin_oe_r <= 1'b0;
            tx_baud_tick_r <= 1'b0;
            rx_baud_tick_r <= 1'b0;
            irq_r <= 1'b0;
            rdata_r <= 8'h00;
        end else if (ce) begin
            shared_port_pin_out_r <= clk_out_nxt;
            shared_port_pin_oe_r <= clk_out_mode;
            tx_baud_tick_r <= ctrl_r.transmit_baud_select ? rollover : other_timer_tx_tick;
            rx_baud_tick_r <= ctrl_r.rx_baud_select ? rollover : other_timer_rx_tick;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_cap_copy;
        is_cap & ext_trig |=> reload_r == $past(count_r);
    endproperty
    a_cap_copy: assert property (p_cap_copy) else $error("capture did not copy count");

    property p_cap_wrap;
        is_cap & ovf_up & ~wr_en |=> count_r == 16'h0000 && ctrl_r.overflow_flag;
    endproperty
    a_cap_wrap: assert property (p_cap_wrap) else $error("capture overflow wrong");

    property p_arl_reload;
        is_arl & ovf_up & ~clk_out_mode & ~wr_en |=> count_r == $past(reload_r) && ctrl_r.overflow_flag;
    endproperty
    a_arl_reload: assert property (p_arl_reload) else $error("reload on overflow missing");

    property p_trig_reload;
        reload_on_trig & ~ovf_up & ~wr_en |=> count_r == $past(reload_r) && ctrl_r.external_flag;
    endproperty
    a_trig_reload: assert property (p_trig_reload) else $error("trigger reload missing");

    property p_underflow;
        unf_dn & ~wr_en |=> count_r == 16'hffff && ctrl_r.overflow_flag;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow load wrong");

    property p_exf_toggle;
        tog_exf & ~wr_en |=> ctrl_r.external_flag != $past(ctrl_r.external_flag);
    endproperty
    a_exf_toggle: assert property (p_exf_toggle) else $error("external flag did not toggle");

    property p_baud_no_tf;
        is_baud & rollover & ~wr_en |=> ctrl_r.overflow_flag == $past(ctrl_r.overflow_flag);
    endproperty
    a_baud_no_tf: assert property (p_baud_no_tf) else $error("baud rollover set flag");

    property p_irq_gate;
        ce & ~ie_r.timer_int_enable |=> ~irq_r;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

    property p_clkout_toggle;
        clk_out_mode & rollover |=> shared_port_pin_out_r != $past(shared_port_pin_out_r);
    endproperty
    a_clkout_toggle: assert property (p_clkout_toggle) else $error("clock-out did not toggle");

    property p_off_hold;
        ce & (op_w == TMR_OFF) & ~wr_en |=> count_r == $past(count_r);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("count moved while off");

    property p_irq_source;
        ce & ie_r.all_enable & ie_r.timer_int_enable & ctrl_r.overflow_flag |=> irq_r;
    endproperty
    a_irq_source: assert property (p_irq_source) else $error("interrupt not raised");

    property p_tx_tick;
        ce & ctrl_r.transmit_baud_select |=> tx_baud_tick_r == $past(rollover);
    endproperty
    a_tx_tick: assert property (p_tx_tick) else $error("transmit tick not from rollover");

    c_capture: cover property (is_cap & ext_trig);
    c_underflow: cover property (unf_dn);
    c_clkout: cover property (clk_out_mode & rollover ##[1:200] clk_out_mode & rollover);
    c_irq: cover property ($rose(irq_r));

endmodule : tmr_core

// file: verilog/tmr_pkg.sv
// Package with register map, field layouts and timing constants of the reload/capture timer
package tmr_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] TMR_IE_ADDR = 8'ha8;
    localparam logic [7:0] TMR_CTRL_ADDR = 8'hc8;
    localparam logic [7:0] TMR_MODE_ADDR = 8'hc9;
    localparam logic [7:0] TMR_RLD_LO_ADDR = 8'hca;
    localparam logic [7:0] TMR_RLD_HI_ADDR = 8'hcb;
    localparam logic [7:0] TMR_CNT_LO_ADDR = 8'hcc;
    localparam logic [7:0] TMR_CNT_HI_ADDR = 8'hcd;

    // ****************************************
    // Reset values and limits
    // ****************************************
    localparam logic [7:0] TMR_CTRL_RST = 8'h00;
    localparam logic [1:0] TMR_MODE_RST = 2'h0;
    localparam logic [7:0] TMR_IE_RST = 8'h00;
    localparam logic [15:0] TMR_CNT_RST = 16'h0000;
    localparam logic [15:0] TMR_RLD_RST = 16'h0000;
    localparam logic [15:0] TMR_CNT_TOP = 16'hffff;

    // ****************************************
    // Timing: oscillator periods per tick and prescaler width
    // ****************************************
    localparam int TMR_MACH_DIV = 12;
    localparam int TMR_STATE_DIV = 2;
    localparam int TMR_PRE_W = 4;

    // ****************************************
    // Field layouts
    // ****************************************
    typedef struct packed {
        logic overflow_flag;
        logic external_flag;
        logic rx_baud_select;
        logic transmit_baud_select;
        logic external_enable;
        logic second_timer_run;
        logic count_source_select;
        logic capture_reload_select;
    } tmr_ctrl_type;

    typedef struct packed {
        logic clock_out_enable;
        logic down_count_enable;
    } tmr_mode_type;

    typedef struct packed {
        logic all_enable;
        logic rsvd6;
        logic timer_int_enable;
        logic [4:0] other_enables;
    } tmr_ie_type;

    typedef enum logic [1:0] {
        TMR_OFF,
        TMR_AUTORELOAD,
        TMR_CAPTURE,
        TMR_BAUD
    } tmr_op_type;

endpackage : tmr_pkg

// file: verilog/tmr_prescale.sv
// Oscillator prescaler giving state-time and machine-cycle ticks
`timescale 1ns/10ps
module tmr_prescale import tmr_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    output logic state_tick,
    output logic mach_tick
);

    logic [TMR_PRE_W-1:0] div_r;
    logic [TMR_PRE_W-1:0] div_nxt;
    wire last_w = (div_r == TMR_PRE_W'(TMR_MACH_DIV - 1));

    assign div_nxt = last_w ? '0 : div_r + TMR_PRE_W'(1);
    assign mach_tick = ce & last_w;
    assign state_tick = ce & div_r[0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_r <= '0;
        end else if (ce) begin
            div_r <= div_nxt;
        end
    end

endmodule : tmr_prescale
